// File: src/hssw_pkg.sv
// Functional notes
// - overcurrent turns output off, sets its irq flag, clears switch_on and pulse_mode_enable.
// - clearing overcurrent flag alone never re-enables; only a new switch_on write does.
// - re-enabling under persisting overcurrent shuts down again with same flag and clears.
// - overtemperature shuts output down, sets its status; restart as after overcurrent.
// - open load sets its status and irq flag only; output keeps running unchanged.
// - open load raises an interrupt only when its enable bit is set.
// - stop or sleep turns and keeps the driver off unless cyclic sense is active.
// - configuration survives stop; a switch that was on resumes after wake-up.
// - cyclic sense supplies the load for a pulse; diagnostics are masked meanwhile.
// - pulse_mode_enable at bit 1 outranks switch_on; output follows selected pulse input.
// - the slew selection applies in both software and pulse modes.
// - bits 13:12 pick one of four overcurrent thresholds, low to high.
// - slew bits 9:8 decode 00 slow, 01 fast, 1x low emission.
// - control bit 3 enables open-load detection.
// - control bit 0 powers the circuit; bit 2 turns the driver on.
// - status bits 14,13 and irq bits 7,6,5; reserved bits read zero.
// - writing one to a status bit sets it, for test.
// - every register accepts byte as well as word writes.
// - source select bits 5:3, code 111 acts as 110, writable only with pulse mode off.
// - writing one to a clear bit clears its status bit; zero does nothing.
// - overcurrent flag is level held while present; overtemp and open-load flags are edge set.
// - the enable register gates overcurrent bit 7, open load 6, overtemperature 5.
`default_nettype none
package hssw_pkg;
  localparam logic [7:0]  ADDR_CTRL     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_CLEAR    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h10;
  localparam logic [7:0]  ADDR_TRIM     = 8'h1C;
  localparam logic [7:0]  ADDR_SRC_SEL  = 8'h24;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_3000;
  localparam logic [31:0] ZERO_RESET    = 32'h0000_0000;
  localparam int          POS_POWER     = 0;
  localparam int          POS_PULSE     = 1;
  localparam int          POS_ON        = 2;
  localparam int          POS_OL_EN     = 3;
  localparam int          POS_SR_LO     = 8;
  localparam int          POS_OC_LO     = 12;
  localparam int          POS_OT_IS     = 5;
  localparam int          POS_OL_IS     = 6;
  localparam int          POS_OC_IS     = 7;
  localparam int          POS_OT_STS    = 13;
  localparam int          POS_OL_STS    = 14;
  localparam int          POS_SRC_LO    = 3;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_330F;
  localparam logic [31:0] STATUS_MASK   = 32'h0000_60E0;
  localparam logic [31:0] IRQ_EN_MASK   = 32'h0000_00E0;
  localparam logic [31:0] TRIM_MASK     = 32'h0000_0303;
  localparam logic [31:0] SRC_MASK      = 32'h0000_0038;
  localparam int          SYNC_STAGES   = 3;

  typedef enum logic [1:0] {
    HSSW_SLEW_SLOW,
    HSSW_SLEW_FAST,
    HSSW_SLEW_LOW_EMC
  } hssw_slew_e;

  typedef struct packed {
    logic overcurrent;
    logic overtemp;
    logic open_load;
  } hssw_sense_s;

  typedef enum logic [1:0] {
    HSSW_RUN,
    HSSW_LOW_POWER,
    HSSW_CYCLIC
  } hssw_mode_e;
endpackage : hssw_pkg
`default_nettype wire

// File: src/hssw_sync.sv
`default_nettype none
module hssw_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [hssw_pkg::SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '0;
      sync_out  <= 1'b0;
    end else begin
      stage_reg <= {stage_reg[hssw_pkg::SYNC_STAGES-2:0], async_in};
      // second and third stage must agree before the level is believed
      if (stage_reg[1] == stage_reg[2]) begin
        sync_out <= stage_reg[2];
      end
    end
  end
endmodule : hssw_sync
`default_nettype wire

// File: src/hssw_top.sv
`default_nettype none
module hssw_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        overcurrent_in,
  input  wire logic        overtemp_in,
  input  wire logic        open_load_in,
  input  wire logic [6:0]  pulse_inputs,
  input  wire logic        low_power_mode,
  input  wire logic        cyclic_sense_active,
  input  wire logic        cyclic_sense_pulse,
  output logic             switch_drive,
  output logic             switch_power,
  output logic [1:0]       slew_code,
  output logic [1:0]       overcurrent_threshold_sel,
  output logic             open_load_detect_active,
  output logic [1:0]       oc_ot_filter_sel,
  output logic [1:0]       open_load_filter_sel,
  output logic             irq
);
  // ==================================================================
  // sense, mode and pulse input synchronisers
  // ==================================================================
  hssw_pkg::hssw_sense_s sense_raw;
  hssw_pkg::hssw_sense_s sense_sync;
  logic                  pulse_sync [6:0];
  logic                  mode_lp_sync;
  logic                  mode_cyc_sync;
  logic                  cyc_pulse_sync;

  assign sense_raw = '{overcurrent: overcurrent_in, overtemp: overtemp_in,
                       open_load: open_load_in};

  hssw_sync u_sync_oc (.pclk(pclk), .presetn(presetn),
                       .async_in(sense_raw.overcurrent), .sync_out(sense_sync.overcurrent));
  hssw_sync u_sync_ot (.pclk(pclk), .presetn(presetn),
                       .async_in(sense_raw.overtemp), .sync_out(sense_sync.overtemp));
  hssw_sync u_sync_ol (.pclk(pclk), .presetn(presetn),
                       .async_in(sense_raw.open_load), .sync_out(sense_sync.open_load));
  hssw_sync u_sync_lp (.pclk(pclk), .presetn(presetn),
                       .async_in(low_power_mode), .sync_out(mode_lp_sync));
  hssw_sync u_sync_cy (.pclk(pclk), .presetn(presetn),
                       .async_in(cyclic_sense_active), .sync_out(mode_cyc_sync));
  hssw_sync u_sync_cp (.pclk(pclk), .presetn(presetn),
                       .async_in(cyclic_sense_pulse), .sync_out(cyc_pulse_sync));

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pulse_sync
      hssw_sync u_sync_pw (.pclk(pclk), .presetn(presetn),
                           .async_in(pulse_inputs[gi]), .sync_out(pulse_sync[gi]));
    end
  endgenerate

  // ==================================================================
  // apb decode
  // ==================================================================
  logic [31:0] ctrl_reg;
  logic [31:0] status_reg;
  logic [31:0] irq_en_reg;
  logic [31:0] trim_reg;
  logic [31:0] src_reg;
  logic [31:0] byte_mask;
  logic        wr_access;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_clear;
  logic        hit_irq_en;
  logic        hit_trim;
  logic        hit_src;
  logic        hit_any;

  assign wr_access  = psel && penable && pwrite;
  assign hit_ctrl   = (paddr == hssw_pkg::ADDR_CTRL);
  assign hit_status = (paddr == hssw_pkg::ADDR_STATUS);
  assign hit_clear  = (paddr == hssw_pkg::ADDR_CLEAR);
  assign hit_irq_en = (paddr == hssw_pkg::ADDR_IRQ_EN);
  assign hit_trim   = (paddr == hssw_pkg::ADDR_TRIM);
  assign hit_src    = (paddr == hssw_pkg::ADDR_SRC_SEL);
  assign hit_any    = hit_ctrl | hit_status | hit_clear | hit_irq_en | hit_trim | hit_src;
  // byte lanes widen to a bit mask so narrow writes touch only their byte
  assign byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !hit_any;

  logic [31:0] wr_bits;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_clear;
  logic        wr_irq_en;
  logic        wr_trim;
  logic        wr_src;

  assign wr_bits   = pwdata & byte_mask;
  assign wr_ctrl   = wr_access && hit_ctrl;
  assign wr_status = wr_access && hit_status;
  assign wr_clear  = wr_access && hit_clear;
  assign wr_irq_en = wr_access && hit_irq_en;
  assign wr_trim   = wr_access && hit_trim;
  assign wr_src    = wr_access && hit_src;

  // ==================================================================
  // protection events
  // ==================================================================
  logic diag_allowed;
  logic oc_event;
  logic ot_event;
  logic ol_seen;
  logic ot_prev_reg;
  logic ol_prev_reg;
  logic ot_rise;
  logic ol_rise;
  logic fault_shutdown;

  // diagnostics are masked while the driver is cyclically pulsed
  assign diag_allowed   = ctrl_reg[hssw_pkg::POS_POWER] && !mode_lp_sync;
  assign oc_event       = diag_allowed && sense_sync.overcurrent;
  assign ot_event       = diag_allowed && sense_sync.overtemp;
  assign ol_seen        = diag_allowed && ctrl_reg[hssw_pkg::POS_OL_EN]
                          && sense_sync.open_load;
  assign ot_rise        = ot_event && !ot_prev_reg;
  assign ol_rise        = ol_seen && !ol_prev_reg;
  // open load is deliberately absent from the shutdown term
  assign fault_shutdown = oc_event || ot_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_prev_reg <= 1'b0;
      ol_prev_reg <= 1'b0;
    end else begin
      ot_prev_reg <= ot_event;
      ol_prev_reg <= ol_seen;
    end
  end

  // ==================================================================
  // control register
  // ==================================================================
  logic [31:0] ctrl_next;
  logic [31:0] ctrl_written;

  assign ctrl_written = (ctrl_reg & ~byte_mask) | (wr_bits & hssw_pkg::CTRL_MASK);

  always_comb begin
    ctrl_next = wr_ctrl ? ctrl_written : ctrl_reg;
    // a fault in the same cycle as a write wins, so a re-enable under
    // persisting overcurrent drops straight back off
    if (fault_shutdown) begin
      ctrl_next[hssw_pkg::POS_ON]    = 1'b0;
      ctrl_next[hssw_pkg::POS_PULSE] = 1'b0;
    end
  end

  // bits are held across low power; nothing here resets on mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= hssw_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==================================================================
  // status register: set by hardware or by software, cleared via clear reg
  // ==================================================================
  logic [31:0] status_next;
  logic [31:0] hw_set;
  logic [31:0] clr_bits;

  always_comb begin
    hw_set = '0;
    hw_set[hssw_pkg::POS_OC_IS]  = oc_event;
    hw_set[hssw_pkg::POS_OT_IS]  = ot_rise;
    hw_set[hssw_pkg::POS_OL_IS]  = ol_rise;
    hw_set[hssw_pkg::POS_OT_STS] = ot_event;
    hw_set[hssw_pkg::POS_OL_STS] = ol_seen;
  end

  assign clr_bits = wr_clear ? (wr_bits & hssw_pkg::STATUS_MASK) : '0;

  // set wins over clear; a software write of one sets too
  assign status_next = ((status_reg & ~clr_bits)
                        | hw_set
                        | (wr_status ? wr_bits : '0)) & hssw_pkg::STATUS_MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= hssw_pkg::ZERO_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==================================================================
  // enable, trim and source select registers
  // ==================================================================
  logic [31:0] irq_en_next;
  logic [31:0] trim_next;
  logic [31:0] src_next;
  logic        src_writable;

  assign irq_en_next  = wr_irq_en ? ((irq_en_reg & ~byte_mask)
                                     | (wr_bits & hssw_pkg::IRQ_EN_MASK)) : irq_en_reg;
  assign trim_next    = wr_trim ? ((trim_reg & ~byte_mask)
                                   | (wr_bits & hssw_pkg::TRIM_MASK)) : trim_reg;
  // source cannot move under a running pulse path
  assign src_writable = wr_src && !ctrl_reg[hssw_pkg::POS_PULSE];
  assign src_next     = src_writable ? ((src_reg & ~byte_mask)
                                        | (wr_bits & hssw_pkg::SRC_MASK)) : src_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= hssw_pkg::ZERO_RESET;
      trim_reg   <= hssw_pkg::ZERO_RESET;
      src_reg    <= hssw_pkg::ZERO_RESET;
    end else begin
      irq_en_reg <= irq_en_next;
      trim_reg   <= trim_next;
      src_reg    <= src_next;
    end
  end

  // ==================================================================
  // read mux
  // ==================================================================
  logic [31:0] rd_data;

  assign rd_data = hit_ctrl   ? ctrl_reg   :
                   hit_status ? status_reg :
                   hit_irq_en ? irq_en_reg :
                   hit_trim   ? trim_reg   :
                   hit_src    ? src_reg    : '0;   // clear register reads zero

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data;
    end
  end

  // ==================================================================
  // power mode tracking
  // ==================================================================
  hssw_pkg::hssw_mode_e mode_reg;
  hssw_pkg::hssw_mode_e mode_next;

  always_comb begin
    case (mode_reg)
      hssw_pkg::HSSW_RUN:
        mode_next = !mode_lp_sync ? hssw_pkg::HSSW_RUN :
                    mode_cyc_sync ? hssw_pkg::HSSW_CYCLIC : hssw_pkg::HSSW_LOW_POWER;
      hssw_pkg::HSSW_LOW_POWER,
      hssw_pkg::HSSW_CYCLIC:
        mode_next = !mode_lp_sync ? hssw_pkg::HSSW_RUN :
                    mode_cyc_sync ? hssw_pkg::HSSW_CYCLIC : hssw_pkg::HSSW_LOW_POWER;
      default:
        mode_next = hssw_pkg::HSSW_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= hssw_pkg::HSSW_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==================================================================
  // output drive
  // ==================================================================
  logic [2:0] src_code;
  logic       pulse_level;
  logic       run_level;
  logic       drive_next;
  logic       power_next;

  // code 111 folds onto 110
  assign src_code    = (src_reg[hssw_pkg::POS_SRC_LO +: 3] == 3'h7) ? 3'h6
                       : src_reg[hssw_pkg::POS_SRC_LO +: 3];
  assign pulse_level = pulse_sync[src_code];
  // pulse mode outranks the static on bit
  assign run_level   = ctrl_reg[hssw_pkg::POS_PULSE] ? pulse_level
                       : ctrl_reg[hssw_pkg::POS_ON];

  always_comb begin
    case (mode_reg)
      hssw_pkg::HSSW_RUN: begin
        drive_next = run_level && ctrl_reg[hssw_pkg::POS_POWER] && !fault_shutdown;
        power_next = ctrl_reg[hssw_pkg::POS_POWER];
      end
      hssw_pkg::HSSW_CYCLIC: begin
        drive_next = cyc_pulse_sync;
        power_next = 1'b1;
      end
      hssw_pkg::HSSW_LOW_POWER: begin
        drive_next = 1'b0;
        power_next = 1'b0;
      end
      default: begin
        drive_next = 1'b0;
        power_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_drive <= 1'b0;
      switch_power <= 1'b0;
    end else begin
      switch_drive <= drive_next;
      switch_power <= power_next;
    end
  end

  // ==================================================================
  // analog settings and interrupt
  // ==================================================================
  hssw_pkg::hssw_slew_e slew_sel;

  // slew applies regardless of pulse or static mode
  assign slew_sel = (ctrl_reg[hssw_pkg::POS_SR_LO +: 2] == 2'h0) ? hssw_pkg::HSSW_SLEW_SLOW :
                    (ctrl_reg[hssw_pkg::POS_SR_LO +: 2] == 2'h1) ? hssw_pkg::HSSW_SLEW_FAST :
                    hssw_pkg::HSSW_SLEW_LOW_EMC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_code                 <= 2'h0;
      overcurrent_threshold_sel <= 2'h0;
      open_load_detect_active   <= 1'b0;
      oc_ot_filter_sel          <= 2'h0;
      open_load_filter_sel      <= 2'h0;
      irq                       <= 1'b0;
    end else begin
      slew_code                 <= slew_sel;
      overcurrent_threshold_sel <= ctrl_reg[hssw_pkg::POS_OC_LO +: 2];
      open_load_detect_active   <= ctrl_reg[hssw_pkg::POS_OL_EN];
      oc_ot_filter_sel          <= trim_reg[9:8];
      open_load_filter_sel      <= trim_reg[1:0];
      irq                       <= |(status_reg & irq_en_reg & hssw_pkg::IRQ_EN_MASK);
    end
  end
endmodule : hssw_top
`default_nettype wire

// File: tb/hssw_top_assertions.sv
`default_nettype none
module hssw_top_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        overcurrent_in,
  input wire logic        overtemp_in,
  input wire logic        low_power_mode,
  input wire logic        cyclic_sense_active,
  input wire logic        switch_drive,
  input wire logic        switch_power,
  input wire logic [1:0]  slew_code,
  input wire logic [1:0]  overcurrent_threshold_sel,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // write decode and expected field values
  logic       wr_ctrl;
  logic       wr_en;
  logic       diag_on;
  logic [1:0] exp_oc;
  logic [1:0] exp_slew;
  assign wr_ctrl = psel && penable && pwrite && (paddr == hssw_pkg::ADDR_CTRL);
  assign wr_en   = psel && penable && pwrite && (paddr == hssw_pkg::ADDR_IRQ_EN);
  // sense inputs only count while diagnostics can run
  assign diag_on = switch_power && !low_power_mode && !cyclic_sense_active;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_oc   <= 2'h3;
      exp_slew <= 2'h0;
    end else if (wr_ctrl && pstrb[1]) begin
      exp_oc   <= pwdata[13:12];
      exp_slew <= pwdata[9] ? 2'h2 : {1'h0, pwdata[8]};
    end
  end
  // ==========================================================
  // assertions
  AST_OC_SHUTDOWN: assert property ((overcurrent_in && diag_on) |-> ##[1:8] !switch_drive)
    else $error("drive stayed on under overcurrent");
  AST_OT_SHUTDOWN: assert property ((overtemp_in && diag_on) |-> ##[1:8] !switch_drive)
    else $error("drive stayed on under overtemperature");
  AST_LP_OFF: assert property ((low_power_mode && !cyclic_sense_active)[*8] |-> !switch_drive)
    else $error("drive on in low power without cyclic sense");
  AST_OC_SEL: assert property ((wr_ctrl && pstrb[1]) |=> ##1 overcurrent_threshold_sel == exp_oc)
    else $error("threshold select not taken from write");
  AST_SLEW_SEL: assert property ((wr_ctrl && pstrb[1]) |=> ##1 slew_code == exp_slew)
    else $error("slew code not decoded from write");
  AST_SLEW_LEGAL: assert property (slew_code != 2'h3)
    else $error("illegal slew code");
  AST_POWER_OFF: assert property ((wr_ctrl && pstrb[0] && !pwdata[0]) |-> ##2 !switch_power)
    else $error("power stayed on after write of zero");
  AST_POWER_ON: assert property ((wr_ctrl && pstrb[0] && pwdata[0] && !low_power_mode)
    |-> ##2 switch_power)
    else $error("power not on after write of one");
  AST_IRQ_GATE: assert property ((wr_en && pstrb[0] && pwdata[7:5] == 3'h0) |-> ##2 !irq)
    else $error("irq high with all sources disabled");
  C_OC: cover property (overcurrent_in ##[1:8] !switch_drive);
  C_IRQ: cover property ($rose(irq));
  C_DRIVE: cover property ($rose(switch_drive));
endmodule : hssw_top_assertions

bind hssw_top hssw_top_assertions u_hssw_top_assertions (.*);
`default_nettype wire

// File: tb/hssw_load_model.sv
`default_nettype none
module hssw_load_model (
  input  wire logic       switch_drive,
  input  wire logic [1:0] overcurrent_threshold_sel,
  input  wire logic [7:0] load_ma,
  input  wire logic       hot,
  output logic            overcurrent_in,
  output logic            overtemp_in,
  output logic            open_load_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // resistive load: current flows only while driven
  logic [7:0] limit_ma;
  assign limit_ma = (overcurrent_threshold_sel == 2'h0) ? 8'h1A :
                    (overcurrent_threshold_sel == 2'h1) ? 8'h33 :
                    (overcurrent_threshold_sel == 2'h2) ? 8'h65 : 8'h97;
  assign overcurrent_in = switch_drive && (load_ma > limit_ma);
  assign open_load_in   = switch_drive && (load_ma < 8'h02);
  // die temperature does not depend on the drive state
  assign overtemp_in    = hot;
endmodule : hssw_load_model
`default_nettype wire

// File: tb/tb_hssw_top.sv
`default_nettype none
module tb_hssw_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = hssw_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = hssw_pkg::ADDR_STATUS;
  localparam logic [7:0] CL = hssw_pkg::ADDR_CLEAR;
  localparam logic [7:0] EN = hssw_pkg::ADDR_IRQ_EN;
  localparam logic [7:0] SR = hssw_pkg::ADDR_SRC_SEL;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [6:0]  pulse_inputs = 7'h00;
  logic        low_power_mode = 1'h0;
  logic        cyclic_sense_active = 1'h0;
  logic        cyclic_sense_pulse = 1'h0;
  logic [7:0]  load_ma = 8'h32;
  logic        hot = 1'h0;
  logic        pready, pslverr, irq, switch_drive, switch_power, open_load_detect_active;
  logic        overcurrent_in, overtemp_in, open_load_in, err;
  logic [1:0]  slew_code, overcurrent_threshold_sel, oc_ot_filter_sel, open_load_filter_sel;
  logic [31:0] prdata, rd;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #5 pclk = ~pclk;
  // every port has a bench signal of the same name
  hssw_top u_hssw_top (.*);
  hssw_load_model u_hssw_load_model (.*);
  // ==========================================================
  // bus and check helpers
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hF);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
  endtask : rchk
  // sense inputs pass a three-stage synchroniser before they act
  task automatic settle;
    repeat (10) @(posedge pclk);
  endtask : settle
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rchk("ctrl rst", CT, 32'h3000);
    rchk("sts rst", ST, 32'h0);
    rchk("src rst", SR, 32'h0);
    rchk("trim rst", hssw_pkg::ADDR_TRIM, 32'h0);
    wr(hssw_pkg::ADDR_TRIM, 32'hFFFF_FFFF);
    rchk("trim", hssw_pkg::ADDR_TRIM, 32'h0303);
    chk("filters", 32'hF, {oc_ot_filter_sel, open_load_filter_sel});
    wr(EN, 32'hFFFF_FFFF);
    rchk("en", EN, 32'hE0);
    wr(EN, 32'h0);
    wr(CT, 32'hFFFF_CCF0);
    rchk("ctrl res", CT, 32'h0);
    rchk("clear rd", CL, 32'h0);
    rchk("unmapped", 8'h00, 32'h0);
    chk("slverr", 32'h1, err);
  endtask : t_regs
  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      wr(CT, (i << 12) | (i << 8) | 32'h1);
      settle();
      chk("slew", (i > 1) ? 32'h2 : i, slew_code);
      chk("oc sel", i, overcurrent_threshold_sel);
    end
    apb(1'h1, CT, 32'h3100, 4'h2);
    rchk("byte wr", CT, 32'h3101);
  endtask : t_cfg
  task automatic t_oc;
    wr(CT, 32'h3005);
    settle();
    chk("drive on", 32'h1, switch_drive);
    load_ma <= 8'hC8;
    settle();
    chk("oc drive", 32'h0, switch_drive);
    rchk("oc ctrl", CT, 32'h3001);
    rchk("oc sts", ST, 32'h80);
    wr(CL, 32'h80);
    settle();
    chk("clr only", 32'h0, switch_drive);
    wr(CT, 32'h3005);
    settle();
    chk("retry drive", 32'h0, switch_drive);
    rchk("retry sts", ST, 32'h80);
    rchk("retry ctrl", CT, 32'h3001);
    load_ma <= 8'h32;
    wr(CL, 32'h80);
    wr(CT, 32'h3005);
    settle();
    chk("restart", 32'h1, switch_drive);
  endtask : t_oc
  task automatic t_ot;
    hot <= 1'h1;
    settle();
    chk("ot drive", 32'h0, switch_drive);
    rchk("ot sts", ST, 32'h2020);
    rchk("ot ctrl", CT, 32'h3001);
    wr(CL, 32'h20);
    rchk("ot edge", ST, 32'h2000);
    hot <= 1'h0;
    settle();
    wr(CL, 32'h2000);
    settle();
    rchk("ot gone", ST, 32'h0);
    wr(CT, 32'h3005);
    settle();
    chk("ot restart", 32'h1, switch_drive);
  endtask : t_ot
  task automatic t_ol;
    wr(CT, 32'h300D);
    load_ma <= 8'h01;
    settle();
    chk("ol det", 32'h1, open_load_detect_active);
    chk("ol drive", 32'h1, switch_drive);
    rchk("ol sts", ST, 32'h4040);
    chk("ol masked", 32'h0, irq);
    wr(EN, 32'h40);
    settle();
    chk("ol irq", 32'h1, irq);
    wr(CL, 32'h4040);
    rchk("ol edge", ST, 32'h4000);
    settle();
    chk("ol irq clr", 32'h0, irq);
    wr(CT, 32'h3005);
    settle();
    wr(CL, 32'h4000);
    settle();
    rchk("ol off", ST, 32'h0);
    load_ma <= 8'h32;
    wr(EN, 32'h0);
  endtask : t_ol
  task automatic t_flags;
    for (int b = 5; b < 8; b++) begin
      wr(ST, 32'h1 << b);
      rchk("force", ST, 32'h1 << b);
      settle();
      chk("irq off", 32'h0, irq);
      wr(EN, 32'h1 << b);
      settle();
      chk("irq on", 32'h1, irq);
      wr(CL, 32'h0);
      apb(1'h1, CL, 32'hFF, 4'hE);
      rchk("no clr", ST, 32'h1 << b);
      wr(CL, 32'h1 << b);
      rchk("clr", ST, 32'h0);
      wr(EN, 32'h0);
    end
  endtask : t_flags
  task automatic t_pulse;
    wr(SR, 32'h38);
    wr(CT, 32'h3107);
    pulse_inputs <= 7'h40;
    settle();
    chk("pw hi", 32'h1, switch_drive);
    chk("pw slew", 32'h1, slew_code);
    pulse_inputs <= 7'h3F;
    settle();
    chk("pw lo", 32'h0, switch_drive);
    wr(SR, 32'h0);
    rchk("src lock", SR, 32'h38);
    wr(CT, 32'h3001);
    pulse_inputs <= 7'h00;
  endtask : t_pulse
  task automatic t_lp;
    wr(CT, 32'h3005);
    low_power_mode <= 1'h1;
    settle();
    chk("lp off", 32'h0, switch_drive);
    rchk("lp keep", CT, 32'h3005);
    low_power_mode <= 1'h0;
    settle();
    chk("wake", 32'h1, switch_drive);
    low_power_mode <= 1'h1;
    cyclic_sense_active <= 1'h1;
    cyclic_sense_pulse <= 1'h1;
    load_ma <= 8'hC8;
    settle();
    chk("cyc on", 32'h1, switch_drive);
    cyclic_sense_pulse <= 1'h0;
    settle();
    chk("cyc off", 32'h0, switch_drive);
    rchk("cyc diag", ST, 32'h0);
  endtask : t_lp
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_cfg();
    t_oc();
    t_ot();
    t_ol();
    t_flags();
    t_pulse();
    t_lp();
    end_of_test();
  end
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
endmodule : tb_hssw_top
`default_nettype wire
